// ### src/adsc_scan_ctrl.sv
// Purpose: Scan range, start, busy and result registers of the analog input converter
// Assumes: Host strobes are one-cycle pulses synchronous to clk
// Notes:   conv_done must come within the documented conversion time; a timeout forces an end
`timescale 1ns/1ps
`default_nettype none
module adsc_scan_ctrl
    import adsc_pkg::*;
#(
    parameter int CODE_W = 12,
    parameter int CHAN_W = 4
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire adsc_bus_t         bus,
    output logic [7:0]             rdata,
    output logic [CHAN_W-1:0]      conv_chan,
    output logic                   conv_start,
    input  wire logic              conv_done,
    input  wire logic [CODE_W-1:0] conv_code
);
    // Result packing and range nibbles are fixed, so other widths are refused at elaboration
    if (CODE_W != 12 || CHAN_W != 4) begin : g_bad_width
        $error("adsc_scan_ctrl: only 12-bit codes and 4-bit channels are served");
    end

    // ************************************
    // Decode
    // ************************************
    logic wr_start;
    logic wr_range;
    assign wr_start = bus.wr && bus.addr == ADSC_OFF_START;
    assign wr_range = bus.wr && bus.addr == ADSC_OFF_RANGE;

    // ************************************
    // Scan range and current channel
    // ************************************
    logic [7:0]        range_q;
    logic [CHAN_W-1:0] cur_q;
    logic [CHAN_W-1:0] first_ch;
    logic [CHAN_W-1:0] last_ch;
    logic              equal;
    logic              busy_q;
    logic              conv_end;
    logic [8:0]        conv_cnt_q;
    logic [8:0]        settle_q;

    assign first_ch = range_q[3:0];  // [R1]
    assign last_ch  = range_q[7:4];  // [R1]
    assign equal    = cur_q == last_ch;  // [R18]

    always_ff @(posedge clk) begin
        if (srst) begin
            range_q <= ADSC_RANGE_RST;
        end else if (wr_range) begin
            range_q <= bus.wdata;  // [R1]
        end
    end

    // Channel steps at start so the result keeps the channel it was taken on
    always_ff @(posedge clk) begin
        if (srst) begin
            cur_q <= '0;
        end else if (wr_range) begin
            cur_q <= bus.wdata[3:0];  // [R2]
        end else if (wr_start && !busy_q) begin
            cur_q <= equal ? first_ch : cur_q + 1'b1;  // [R4] [R5]
        end
    end

    // ************************************
    // Conversion sequence
    // ************************************
    logic [CHAN_W-1:0] conv_chan_q;
    assign conv_start = wr_start && !busy_q;  // [R6] [R20]
    assign conv_chan  = conv_chan_q;
    assign conv_end   = busy_q && (conv_done || conv_cnt_q == 9'(ADSC_CONV_MAX_CYC - 1));  // [R7]

    always_ff @(posedge clk) begin
        if (srst) begin
            conv_chan_q <= '0;
        end else if (conv_start) begin
            conv_chan_q <= cur_q;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            busy_q     <= 1'b0;
            conv_cnt_q <= '0;
        end else if (conv_start) begin
            busy_q     <= 1'b1;  // [R8]
            conv_cnt_q <= '0;
        end else if (conv_end) begin
            busy_q     <= 1'b0;  // [R9]
        end else if (busy_q) begin
            conv_cnt_q <= conv_cnt_q + 9'd1;
        end
    end

    // Code passes through as unsigned; polarity is set in the front end
    adsc_result_t res_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            res_q <= '0;
        end else if (conv_end) begin
            res_q.code <= conv_code;  // [R14] [R15] [R16] [R19]
            res_q.chan <= conv_chan_q;
        end
    end

    // ************************************
    // Settling timer
    // ************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            settle_q <= '0;
        end else if (wr_range) begin
            settle_q <= 9'(ADSC_SETTLE_CYC);  // [R17]
        end else if (settle_q != '0) begin
            settle_q <= settle_q - 9'd1;
        end
    end

    // ************************************
    // Read mux
    // ************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= ADSC_UNMAPPED_RD;
        end else if (bus.rd) begin
            case (bus.addr)
                ADSC_OFF_RES_LO:   rdata <= {res_q.code[3:0], res_q.chan};  // [R11] [R12]
                ADSC_OFF_RES_HI:   rdata <= res_q.code[11:4];  // [R13]
                ADSC_OFF_RANGE:    rdata <= range_q;
                ADSC_OFF_STATUS:   rdata <= {busy_q, 7'h00};  // [R8]
                ADSC_OFF_READBACK: rdata <= {3'h0, settle_q != '0, 1'b0, equal, 2'h0};  // [R17] [R18]
                default:           rdata <= ADSC_UNMAPPED_RD;
            endcase
        end
    end

    // ************************************
    // Checks
    // ************************************
    sequence range_wr_s;
        wr_range;
    endsequence

    range_load_a: assert property (@(posedge clk) disable iff (srst)
        range_wr_s |=> cur_q == $past(bus.wdata[3:0]))  // [R2]
        else $error("channel not loaded from range write");

    range_field_a: assert property (@(posedge clk) disable iff (srst)
        wr_range |=> first_ch == $past(bus.wdata[3:0]) && last_ch == $past(bus.wdata[7:4]))  // [R1]
        else $error("range fields wrong");

    chan_step_a: assert property (@(posedge clk) disable iff (srst)
        conv_start && !wr_range && !equal |=> cur_q == $past(cur_q) + 1'b1)  // [R4]
        else $error("channel did not advance");

    chan_wrap_a: assert property (@(posedge clk) disable iff (srst)
        conv_start && !wr_range && equal |=> cur_q == $past(first_ch))  // [R5]
        else $error("channel did not wrap");

    start_busy_a: assert property (@(posedge clk) disable iff (srst)
        wr_start && !busy_q |=> busy_q)  // [R6]
        else $error("start did not set busy");

    conv_time_a: assert property (@(posedge clk) disable iff (srst)
        conv_start |=> busy_q [*1] ##[0:400] !busy_q)  // [R7]
        else $error("conversion too long");

    busy_res_a: assert property (@(posedge clk) disable iff (srst)
        $fell(busy_q) |-> res_q.code == $past(conv_code) && res_q.chan == $past(conv_chan_q))  // [R9] [R19]
        else $error("busy fell without result");

    busy_ignore_a: assert property (@(posedge clk) disable iff (srst)
        wr_start && busy_q && !wr_range |=> $stable(cur_q) && $stable(conv_chan_q))  // [R20]
        else $error("start while busy disturbed sequence");

    settle_len_a: assert property (@(posedge clk) disable iff (srst)
        wr_range |=> settle_q == 9'(ADSC_SETTLE_CYC))  // [R17]
        else $error("settle timer not loaded");

    stat_rd_a: assert property (@(posedge clk) disable iff (srst)
        bus.rd && bus.addr == ADSC_OFF_STATUS |=> rdata == {$past(busy_q), 7'h00})  // [R8]
        else $error("status byte wrong");

    lo_byte_a: assert property (@(posedge clk) disable iff (srst)
        bus.rd && bus.addr == ADSC_OFF_RES_LO |=> rdata == {$past(res_q.code[3:0]), $past(res_q.chan)})  // [R12]
        else $error("low result byte wrong");

    hi_byte_a: assert property (@(posedge clk) disable iff (srst)
        bus.rd && bus.addr == ADSC_OFF_RES_HI |=> rdata == $past(res_q.code[11:4]))  // [R13]
        else $error("high result byte wrong");
endmodule : adsc_scan_ctrl
`default_nettype wire

// ### src/adsc_pkg.sv
// Purpose: Constants and types for the conversion scan control block
// Assumes: 8-bit host I/O bus, byte registers at base-relative offsets, 40 MHz clock
// Notes:   The analog converter itself sits outside; it is driven by start and answers with done
//
// Notes on behaviour
// (R1) Range byte: low nibble first, high nibble last
// (R2) Range write loads current channel with first
// (R3) Host waits about 10 us before starting
// (R4) Each conversion advances current channel
// (R5) After last channel, wrap to first
// (R6) Any write to offset 0 starts conversion
// (R7) Conversion finishes within 10 us
// (R8) Status bit 7 is busy flag
// (R9) Busy clears only once result readable
// (R10) Host polls busy with mask 0x80
// (R11) Result read as two bytes
// (R12) Low byte: result low nibble, channel
// (R13) High byte holds upper eight result bits
// (R14) Codes are unsigned 0 through 4095
// (R15) Unipolar: code step is full scale/4096
// (R16) Bipolar: offset binary, 2048 is zero
// (R17) Settle bit high 10 us after range write
// (R18) Equal bit when current channel is last
// (R19) Busy and result bytes update together
// (R20) Start while busy is ignored
package adsc_pkg;
    // ************************************
    // Register offsets
    // ************************************
    localparam logic [3:0] ADSC_OFF_START    = 4'h0;
    localparam logic [3:0] ADSC_OFF_RES_LO   = 4'h0;
    localparam logic [3:0] ADSC_OFF_RES_HI   = 4'h1;
    localparam logic [3:0] ADSC_OFF_RANGE    = 4'h2;
    localparam logic [3:0] ADSC_OFF_STATUS   = 4'h8;
    localparam logic [3:0] ADSC_OFF_READBACK = 4'hb;

    // ************************************
    // Field positions and reset values
    // ************************************
    localparam int         ADSC_STAT_BUSY_BIT = 7;
    localparam int         ADSC_RB_SETTLE_BIT = 4;
    localparam int         ADSC_RB_EQUAL_BIT  = 2;
    localparam logic [7:0] ADSC_RANGE_RST     = 8'h00;
    localparam logic [7:0] ADSC_UNMAPPED_RD   = 8'h00;

    // ************************************
    // Timing
    // ************************************
    localparam int ADSC_CLK_MHZ      = 40;
    localparam int ADSC_SETTLE_US    = 10;
    localparam int ADSC_CONV_MAX_US  = 10;
    localparam int ADSC_SETTLE_CYC   = ADSC_SETTLE_US * ADSC_CLK_MHZ;
    localparam int ADSC_CONV_MAX_CYC = ADSC_CONV_MAX_US * ADSC_CLK_MHZ;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [7:0]  wdata;
    } adsc_bus_t;

    typedef struct packed {
        logic [11:0] code;
        logic [3:0]  chan;
    } adsc_result_t;
endpackage : adsc_pkg

// ### bench/adsc_conv_model.sv
// Purpose: Behavioural converter answering start with done after a set latency
// Assumes: lat stays below the 10 us bound
// Notes:   Code lines carry a moving pattern outside the done cycle
`timescale 1ns/1ps
`default_nettype none
module adsc_conv_model (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        conv_start,
    input  wire logic [11:0] code_in,
    input  wire logic [8:0]  lat,
    output logic             conv_done,
    output logic [11:0]      conv_code
);
    logic [8:0]  cnt_q;
    logic        run_q;
    logic [11:0] junk_q;
    assign conv_done = run_q && (cnt_q == 9'h000);
    assign conv_code = conv_done ? code_in : junk_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            junk_q <= 12'h5a3;
        end else begin
            junk_q <= junk_q + 12'h9a5;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            run_q <= 1'b0;
            cnt_q <= 9'h000;
        end else if (conv_start && !run_q) begin
            run_q <= 1'b1;
            cnt_q <= lat;
        end else if (run_q && cnt_q != 9'h000) begin
            cnt_q <= cnt_q - 9'h001;
        end else begin
            run_q <= 1'b0;
        end
    end
endmodule : adsc_conv_model
`default_nettype wire

// ### bench/tb_adsc_scan_ctrl.sv
// Purpose: Self-checking bench for the scan conversion control
// Assumes: Host bus strobes one cycle wide, driven at rising edges
// Notes:   Random codes and latencies from an LFSR with a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb_adsc_scan_ctrl;
    import adsc_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    adsc_bus_t   bus = '0;
    logic [7:0]  rdata;
    logic [3:0]  conv_chan;
    logic        conv_start;
    logic        conv_done;
    logic [11:0] conv_code;
    logic [11:0] code_in = 12'h000;
    logic [8:0]  lat = 9'h014;
    logic [31:0] seed = 32'hd60f8a31;
    logic [7:0]  d;
    logic [7:0]  starts = 8'h00;
    logic [7:0]  exp_starts = 8'h00;
    int          bad_count = 0;
    int          tests_run = 0;
    always #12.5 clk = ~clk;
    always @(posedge clk) if (conv_start === 1'b1) starts <= starts + 8'h01;
    adsc_scan_ctrl adsc_scan_ctrl_inst (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
        .conv_chan(conv_chan), .conv_start(conv_start), .conv_done(conv_done), .conv_code(conv_code));
    adsc_conv_model adsc_conv_model_inst (.clk(clk), .srst(srst), .conv_start(conv_start),
        .code_in(code_in), .lat(lat), .conv_done(conv_done), .conv_code(conv_code));
    // ************************************
    // Helpers
    // ************************************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        bus <= {1'b1, 1'b0, a, v};
        @(posedge clk);
        bus <= '0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        bus <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        bus <= '0;
        #1 d = rdata;
    endtask : rd
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    // One conversion on channel ch, with a stray start while busy
    task automatic conv(input logic [3:0] ch, input logic [11:0] c, input logic [3:0] last);
        int n;
        rd(ADSC_OFF_READBACK);
        check(d & 8'h04, (ch == last) ? 8'h04 : 8'h00);
        seed = lfsr(seed);
        code_in <= c;
        lat <= 9'h014 + {1'b0, seed[7:0]};
        exp_starts = exp_starts + 8'h01;
        wr(ADSC_OFF_START, seed[15:8]);
        #1 check({4'h0, conv_chan}, {4'h0, ch});
        wr(ADSC_OFF_START, 8'hff);
        rd(ADSC_OFF_STATUS);
        check(d & 8'h80, 8'h80);
        n = 0;
        do begin
            rd(ADSC_OFF_STATUS);
            n++;
        end while (d[7] !== 1'b0 && n < 300);
        check(d & 8'h80, 8'h00);
        check(starts, exp_starts);
        rd(ADSC_OFF_RES_LO);
        check(d, {c[3:0], ch});
        rd(ADSC_OFF_RES_HI);
        check(d, c[11:4]);
    endtask : conv
    // ************************************
    // Main sequence
    // ************************************
    initial begin
        logic [7:0]  rng [3];
        logic [3:0]  ch;
        logic [11:0] c;
        rng = '{8'h20, 8'h55, 8'hfd};
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rd(ADSC_OFF_STATUS);
        check(d, 8'h00);
        rd(ADSC_OFF_RANGE);
        check(d, ADSC_RANGE_RST);
        rd(4'h3);
        check(d, ADSC_UNMAPPED_RD);
        $display("test reset done");
        for (int r = 0; r < 3; r++) begin
            wr(ADSC_OFF_RANGE, rng[r]);
            rd(ADSC_OFF_RANGE);
            check(d, rng[r]);
            rd(ADSC_OFF_READBACK);
            check(d & 8'h10, 8'h10);
            repeat (ADSC_SETTLE_CYC) @(posedge clk); // Host settle wait
            rd(ADSC_OFF_READBACK);
            check(d & 8'h10, 8'h00);
            ch = rng[r][3:0];
            for (int i = 0; i < 5; i++) begin
                seed = lfsr(seed);
                c = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : seed[27:16];
                conv(ch, c, rng[r][7:4]);
                ch = (ch == rng[r][7:4]) ? rng[r][3:0] : ch + 4'h1;
            end
            $display("test range %h done", rng[r]);
        end
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end
endmodule : tb_adsc_scan_ctrl
`default_nettype wire
